/* File: dwmb_pkg.sv */
// Shared constants and types for the width, mask and bank-set data path
package dwmb_pkg;

    localparam int unsigned PINS = 16;
    localparam int unsigned SLOTS = 16;
    localparam int unsigned BUS_W = 256;

    // Device width codes
    localparam logic [2:0] WIDTH_X1 = 3'h0;
    localparam logic [2:0] WIDTH_X2 = 3'h1;
    localparam logic [2:0] WIDTH_X4 = 3'h2;
    localparam logic [2:0] WIDTH_X8 = 3'h3;
    localparam logic [2:0] WIDTH_X16 = 3'h4;
    localparam logic [2:0] WIDTH_RESET = WIDTH_X16;

    // Register word offsets (byte address = 4 * index)
    localparam logic [1:0] REG_CFG = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_WRCNT = 2'h2;
    localparam logic [1:0] REG_RDCNT = 2'h3;

    // Field positions
    localparam int unsigned CFG_WIDTH_LSB = 0;
    localparam int unsigned ST_LAST_WR_SET = 0;
    localparam int unsigned ST_LAST_RD_SET = 1;
    localparam int unsigned ST_LAST_MASKED = 2;
    localparam int unsigned ST_WIDTH_BAD = 3;

    // Column request from the request decoder
    typedef struct packed {
        logic valid;
        logic masked;
        logic [2:0] bank;
        logic [3:0] subcolumn_select;
        logic [7:0] mask;
    } dwmb_col_req_t;

    // One core bus write transfer toward a bank set
    typedef struct packed {
        logic valid;
        logic [BUS_W-1:0] data;
        logic [31:0] byte_en;
    } dwmb_core_wr_t;

endpackage : dwmb_pkg

/* File: dwmb_width_map.sv */
// Width and sub-column mapping between the pin data bus and the core bus
`timescale 1ns/1ps
module dwmb_width_map
(
    // Configuration
    input wire logic [2:0] width_i,
    input wire logic [3:0] subcolumn_select_i,
    // Write direction: pin-major packet in, core sets out
    input wire logic [255:0] pin_data_i,
    output logic [255:0] core_data_o,
    output logic [15:0] set_sel_o,
    // Read direction: core sets in, pin-major packet out
    input wire logic [255:0] core_rd_i,
    output logic [255:0] pin_rd_o,
    output logic [15:0] pin_en_o,
    output logic width_bad_o
);

    function automatic logic [2:0] width_log2(input logic [2:0] w);
        case (w)
            dwmb_pkg::WIDTH_X1: width_log2 = 3'h0;
            dwmb_pkg::WIDTH_X2: width_log2 = 3'h1;
            dwmb_pkg::WIDTH_X4: width_log2 = 3'h2;
            dwmb_pkg::WIDTH_X8: width_log2 = 3'h3;
            default: width_log2 = 3'h4;
        endcase
    endfunction : width_log2

    always_comb
    begin
        logic [2:0] k;
        logic [3:0] lowmask;
        logic [3:0] blk;
        logic [3:0] pin;
        logic [3:0] set;
        pin = 4'h0;
        set = 4'h0;
        k = width_log2(width_i);
        lowmask = 4'((5'h01 << k) - 5'h01);
        // Low sub-column bits are dropped as width grows
        blk = subcolumn_select_i & ~lowmask;
        width_bad_o = (width_i > dwmb_pkg::WIDTH_X16);
        core_data_o = '0;
        set_sel_o = '0;
        pin_rd_o = '0;
        pin_en_o = '0;
        for (int j = 0; j < 16; j++)
        begin
            pin = 4'(j) & lowmask;
            if (!width_bad_o && ((4'(j) & ~lowmask) == blk))
            begin
                core_data_o[j*16 +: 16] = pin_data_i[pin*16 +: 16];
                set_sel_o[j] = 1'b1;
            end
        end
        for (int i = 0; i < 16; i++)
        begin
            set = blk | (4'(i) & lowmask);
            if (!width_bad_o && ((4'(i) & ~lowmask) == 4'h0))
            begin
                pin_rd_o[i*16 +: 16] = core_rd_i[set*16 +: 16];
                pin_en_o[i] = 1'b1;
            end
        end
    end

endmodule : dwmb_width_map

/* File: dwmb_byte_mask.sv */
// Byte write enables from a mask value compare
`timescale 1ns/1ps
module dwmb_byte_mask
(
    // Core-side write bus after width mapping
    input wire logic [255:0] mask_input_bus_i,
    input wire logic [15:0] set_sel_i,
    // Mask control
    input wire logic masked_i,
    input wire logic [7:0] mask_i,
    // One enable per byte
    output logic [31:0] byte_en_o
);

    always_comb
    begin
        for (int b = 0; b < 32; b++)
        begin
            // Equal bytes stay unwritten
            byte_en_o[b] = set_sel_i[b/2] &&
                (!masked_i || (mask_input_bus_i[b*8 +: 8] != mask_i));
        end
    end

endmodule : dwmb_byte_mask

/* File: dwmb_top.sv */
// Dynamic width, byte mask and even/odd bank-set core bus data path
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module dwmb_top
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // Avalon-MM register slave
    input wire logic [1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Column requests from the request decoder
    input wire dwmb_pkg::dwmb_col_req_t WR_REQ_I,
    input wire dwmb_pkg::dwmb_col_req_t RD_REQ_I,
    // Deserialised write packet, pin-major, slot 0 in bit 0
    input wire logic [255:0] WR_PIN_DATA_I,
    // Core buses of the two bank sets
    output dwmb_pkg::dwmb_core_wr_t EVEN_SET_CORE_WR_O,
    output dwmb_pkg::dwmb_core_wr_t ODD_SET_CORE_WR_O,
    input wire logic [255:0] EVEN_SET_CORE_BUS_I,
    input wire logic [255:0] ODD_SET_CORE_BUS_I,
    // Read packet toward the serialiser
    output logic RD_VALID_O,
    output logic [255:0] RD_PIN_DATA_O,
    output logic [15:0] RD_PIN_EN_O
);

    // Register bus state
    logic [2:0] cfg_width_q;
    logic [2:0] cfg_width_d;
    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [15:0] wr_cnt_q;
    logic [15:0] wr_cnt_d;
    logic [15:0] mwr_cnt_q;
    logic [15:0] mwr_cnt_d;
    logic [15:0] rd_cnt_q;
    logic [15:0] rd_cnt_d;
    logic [3:0] status_q;
    logic [3:0] status_d;

    // Data path state
    dwmb_pkg::dwmb_core_wr_t even_wr_q;
    dwmb_pkg::dwmb_core_wr_t even_wr_d;
    dwmb_pkg::dwmb_core_wr_t odd_wr_q;
    dwmb_pkg::dwmb_core_wr_t odd_wr_d;
    logic rd_valid_q;
    logic rd_valid_d;
    logic [255:0] rd_data_q;
    logic [255:0] rd_data_d;
    logic [15:0] rd_en_q;
    logic [15:0] rd_en_d;

    // Mapping results
    logic [255:0] wr_core_data;
    logic [15:0] wr_set_sel;
    logic [31:0] wr_byte_en;
    logic wr_width_bad;
    logic [255:0] rd_core_bus;
    logic [255:0] rd_pin_data;
    logic [15:0] rd_pin_en;
    logic rd_width_bad;
    logic bus_req;
    logic bus_take;

    // Write direction mapping; read side of this instance unused
    dwmb_width_map u_wr_map
    (
        .width_i(cfg_width_q),
        .subcolumn_select_i(WR_REQ_I.subcolumn_select),
        .pin_data_i(WR_PIN_DATA_I),
        .core_data_o(wr_core_data),
        .set_sel_o(wr_set_sel),
        .core_rd_i('0),
        .pin_rd_o(),
        .pin_en_o(),
        .width_bad_o(wr_width_bad)
    );

    dwmb_byte_mask u_mask
    (
        .mask_input_bus_i(wr_core_data),
        .set_sel_i(wr_set_sel),
        .masked_i(WR_REQ_I.masked),
        .mask_i(WR_REQ_I.mask),
        .byte_en_o(wr_byte_en)
    );

    // Read source is the core bus of the addressed set
    assign rd_core_bus = RD_REQ_I.bank[0] ? ODD_SET_CORE_BUS_I : EVEN_SET_CORE_BUS_I;

    dwmb_width_map u_rd_map
    (
        .width_i(cfg_width_q),
        .subcolumn_select_i(RD_REQ_I.subcolumn_select),
        .pin_data_i('0),
        .core_data_o(),
        .set_sel_o(),
        .core_rd_i(rd_core_bus),
        .pin_rd_o(rd_pin_data),
        .pin_en_o(rd_pin_en),
        .width_bad_o(rd_width_bad)
    );

    // Write path: masked and plain writes share the same one-cycle latency
    always_comb
    begin
        even_wr_d = '0;
        odd_wr_d = '0;
        if (WR_REQ_I.valid && !wr_width_bad)
        begin
            if (WR_REQ_I.bank[0])
            begin
                odd_wr_d.valid = 1'b1;
                odd_wr_d.data = wr_core_data;
                odd_wr_d.byte_en = wr_byte_en;
            end
            else
            begin
                even_wr_d.valid = 1'b1;
                even_wr_d.data = wr_core_data;
                even_wr_d.byte_en = wr_byte_en;
            end
        end
    end

    // Read path runs beside the write path, so both sets work at once
    always_comb
    begin
        rd_valid_d = RD_REQ_I.valid && !rd_width_bad;
        rd_data_d = rd_valid_d ? rd_pin_data : '0;
        rd_en_d = rd_valid_d ? rd_pin_en : '0;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RSTN_I)
        begin
            even_wr_q <= '0;
            odd_wr_q <= '0;
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
            rd_en_q <= '0;
        end
        else
        begin
            even_wr_q <= even_wr_d;
            odd_wr_q <= odd_wr_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            rd_en_q <= rd_en_d;
        end
    end

    // Register slave: one wait cycle, then the access completes
    always_comb
    begin
        bus_req = AVS_READ_I || AVS_WRITE_I;
        bus_take = bus_req && !wait_q;
        wait_d = !(bus_req && wait_q);
        cfg_width_d = cfg_width_q;
        if (bus_take && AVS_WRITE_I && (AVS_ADDRESS_I == dwmb_pkg::REG_CFG))
        begin
            cfg_width_d = AVS_WRITEDATA_I[dwmb_pkg::CFG_WIDTH_LSB +: 3];
        end
        rdata_d = rdata_q;
        if (bus_req && wait_q && AVS_READ_I)
        begin
            case (AVS_ADDRESS_I)
                dwmb_pkg::REG_CFG: rdata_d = {29'h0, cfg_width_q};
                dwmb_pkg::REG_STATUS: rdata_d = {28'h0, status_q};
                dwmb_pkg::REG_WRCNT: rdata_d = {mwr_cnt_q, wr_cnt_q};
                dwmb_pkg::REG_RDCNT: rdata_d = {16'h0, rd_cnt_q};
                default: rdata_d = 32'h0;
            endcase
        end
        wr_cnt_d = wr_cnt_q + 16'((WR_REQ_I.valid && !wr_width_bad) ? 1 : 0);
        mwr_cnt_d = mwr_cnt_q +
            16'((WR_REQ_I.valid && !wr_width_bad && WR_REQ_I.masked) ? 1 : 0);
        rd_cnt_d = rd_cnt_q + 16'(rd_valid_d ? 1 : 0);
        status_d = status_q;
        status_d[dwmb_pkg::ST_WIDTH_BAD] = (cfg_width_q > dwmb_pkg::WIDTH_X16);
        if (WR_REQ_I.valid && !wr_width_bad)
        begin
            status_d[dwmb_pkg::ST_LAST_WR_SET] = WR_REQ_I.bank[0];
            status_d[dwmb_pkg::ST_LAST_MASKED] = WR_REQ_I.masked;
        end
        if (rd_valid_d)
        begin
            status_d[dwmb_pkg::ST_LAST_RD_SET] = RD_REQ_I.bank[0];
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RSTN_I)
        begin
            cfg_width_q <= dwmb_pkg::WIDTH_RESET;
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
            wr_cnt_q <= 16'h0;
            mwr_cnt_q <= 16'h0;
            rd_cnt_q <= 16'h0;
            status_q <= 4'h0;
        end
        else
        begin
            cfg_width_q <= cfg_width_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            wr_cnt_q <= wr_cnt_d;
            mwr_cnt_q <= mwr_cnt_d;
            rd_cnt_q <= rd_cnt_d;
            status_q <= status_d;
        end
    end

    assign AVS_READDATA_O = rdata_q;
    assign AVS_WAITREQUEST_O = wait_q;
    assign EVEN_SET_CORE_WR_O = even_wr_q;
    assign ODD_SET_CORE_WR_O = odd_wr_q;
    assign RD_VALID_O = rd_valid_q;
    assign RD_PIN_DATA_O = rd_data_q;
    assign RD_PIN_EN_O = rd_en_q;

endmodule : dwmb_top

/* File: dwmb_properties.sv */
// Port checker for the width, mask and bank-set data path
`timescale 1ns/1ps
module dwmb_properties
(
    // Clock, reset, register writes
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic [1:0] AVS_ADDRESS_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic AVS_WAITREQUEST_O,
    // Column path
    input wire dwmb_pkg::dwmb_col_req_t WR_REQ_I,
    input wire dwmb_pkg::dwmb_col_req_t RD_REQ_I,
    input wire logic [255:0] WR_PIN_DATA_I,
    input wire dwmb_pkg::dwmb_core_wr_t EVEN_SET_CORE_WR_O,
    input wire dwmb_pkg::dwmb_core_wr_t ODD_SET_CORE_WR_O,
    input wire logic [255:0] EVEN_SET_CORE_BUS_I,
    input wire logic [255:0] ODD_SET_CORE_BUS_I,
    input wire logic RD_VALID_O,
    input wire logic [255:0] RD_PIN_DATA_O,
    input wire logic [15:0] RD_PIN_EN_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Width shadow keeps refused codes out of scope
    logic [2:0] w_q;
    logic odd_q;
    logic hit_q;
    logic [255:0] wd_q;
    logic [255:0] rd_q;
    wire ok = w_q <= 3'h4;
    wire dwmb_pkg::dwmb_core_wr_t cw = odd_q ? ODD_SET_CORE_WR_O : EVEN_SET_CORE_WR_O;
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RSTN_I)
            w_q <= 3'h4;
        else if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 2'h0)
            w_q <= AVS_WRITEDATA_I[2:0];
        odd_q <= WR_REQ_I.bank[0];
        hit_q <= WR_PIN_DATA_I[7:0] != WR_REQ_I.mask;
        wd_q <= WR_PIN_DATA_I;
        rd_q <= RD_REQ_I.bank[0] ? ODD_SET_CORE_BUS_I : EVEN_SET_CORE_BUS_I;
    end
    set_route_a: assert property (WR_REQ_I.valid && ok |=>
        ODD_SET_CORE_WR_O.valid == odd_q && EVEN_SET_CORE_WR_O.valid != odd_q) else $error("route");
    wr_drop_a: assert property (!(WR_REQ_I.valid && ok) |=>
        !ODD_SET_CORE_WR_O.valid && !EVEN_SET_CORE_WR_O.valid) else $error("stray write");
    full_data_a: assert property (WR_REQ_I.valid && w_q == 3'h4 |=> cw.data == wd_q)
        else $error("x16 data");
    plain_en_a: assert property (WR_REQ_I.valid && !WR_REQ_I.masked && w_q == 3'h4
        |=> &cw.byte_en) else $error("plain enables");
    mask_cmp_a: assert property (WR_REQ_I.valid && WR_REQ_I.masked && w_q == 3'h4
        |=> cw.byte_en[0] == hit_q) else $error("mask compare");
    rd_full_a: assert property (RD_REQ_I.valid && w_q == 3'h4 |=> RD_VALID_O
        && RD_PIN_DATA_O == rd_q && &RD_PIN_EN_O) else $error("x16 read");
    rd_x4_a: assert property (RD_REQ_I.valid && w_q == 3'h2 |=> RD_PIN_EN_O == 16'h000F
        && RD_PIN_DATA_O[255:64] == '0) else $error("x4 read");
    rd_quiet_a: assert property (!(RD_REQ_I.valid && ok) |=> !RD_VALID_O) else $error("read");
    cover property (WR_REQ_I.valid && WR_REQ_I.masked);
    cover property (RD_REQ_I.valid && w_q == 3'h0);
    cover property (WR_REQ_I.valid ##1 WR_REQ_I.valid ##1 WR_REQ_I.valid);
endmodule : dwmb_properties
bind dwmb_top dwmb_properties u_props (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .WR_REQ_I(WR_REQ_I), .RD_REQ_I(RD_REQ_I),
    .WR_PIN_DATA_I(WR_PIN_DATA_I), .EVEN_SET_CORE_WR_O(EVEN_SET_CORE_WR_O),
    .ODD_SET_CORE_WR_O(ODD_SET_CORE_WR_O), .EVEN_SET_CORE_BUS_I(EVEN_SET_CORE_BUS_I),
    .ODD_SET_CORE_BUS_I(ODD_SET_CORE_BUS_I), .RD_VALID_O(RD_VALID_O),
    .RD_PIN_DATA_O(RD_PIN_DATA_O), .RD_PIN_EN_O(RD_PIN_EN_O));

/* File: dwmb_ctrl_model.sv */
// Controller model: column requests and write packets
`timescale 1ns/1ps
module dwmb_ctrl_model
(
    // Clock
    input wire logic clk_i,
    // Request bus and write pins
    output dwmb_pkg::dwmb_col_req_t wr_req_o,
    output dwmb_pkg::dwmb_col_req_t rd_req_o,
    output logic [255:0] wr_pin_data_o
);
    initial
    begin
        wr_req_o = '0;
        rd_req_o = '0;
        wr_pin_data_o = '0;
    end
    // Negative mk: pick a value found in no byte of the packet
    task automatic wcol(input logic [2:0] b, input logic [3:0] sc, input logic m, input int mk,
        input logic [255:0] d);
        logic [255:0] seen;
        logic [7:0] mv;
        seen = '0;
        mv = mk[7:0];
        for (int i = 0; i < 32; i++)
            seen[d[i*8+:8]] = 1'b1;
        for (int v = 255; v >= 0; v--)
            if (mk < 0 && !seen[v])
                mv = v[7:0];
        wr_req_o <= '{1'b1, m, b, sc, mv};
        wr_pin_data_o <= d;
    endtask : wcol
    // Caller issues reads in the same cycle as writes to the same set; no activates are modelled
    task automatic rcol(input logic [2:0] b, input logic [3:0] sc);
        rd_req_o <= '{1'b1, 1'b0, b, sc, 8'h00};
    endtask : rcol
    // Released pins show the inverse so stale data cannot pass
    task idle;
        wr_req_o.valid <= 1'b0;
        rd_req_o.valid <= 1'b0;
        wr_pin_data_o <= ~wr_pin_data_o;
    endtask : idle
endmodule : dwmb_ctrl_model

/* File: dwmb_top_bench.sv */
// Self-checking bench for the width, mask and bank-set data path
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t %0h %0h", $time, a, b); end end
module dwmb_top_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rv;
    logic wait_rq;
    logic rvld;
    logic sel;
    logic [15:0] ren;
    logic [255:0] wpin, rpin, ebus, obus, dw, dm, rb;
    dwmb_pkg::dwmb_col_req_t wq, rq;
    dwmb_pkg::dwmb_core_wr_t ev, od, cw;
    int num_errors = 0;
    int cmp_count = 0;
    int pins, lm;
    always #5 clk = ~clk;
    dwmb_top dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wait_rq), .WR_REQ_I(wq), .RD_REQ_I(rq), .WR_PIN_DATA_I(wpin),
        .EVEN_SET_CORE_WR_O(ev), .ODD_SET_CORE_WR_O(od), .EVEN_SET_CORE_BUS_I(ebus),
        .ODD_SET_CORE_BUS_I(obus), .RD_VALID_O(rvld), .RD_PIN_DATA_O(rpin), .RD_PIN_EN_O(ren));
    dwmb_ctrl_model u_ctrl (.clk_i(clk), .wr_req_o(wq), .rd_req_o(rq), .wr_pin_data_o(wpin));
    // Never called twice in one step, so read and write never clash
    task avs(input logic w, input logic [1:0] a, input logic [31:0] d);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wait_rq)
            @(posedge clk);
        rv = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : avs
    task stop_test;
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (2000) @(posedge clk);
        num_errors++;
        stop_test;
    end
    initial
    begin
        for (int i = 0; i < 16; i++)
            dw[i*16+:16] = 16'(i * 16'h0F1E + 16'h0123);
        dm = {{31{8'hA5}}, 8'h3C};
        ebus = ~dw;
        obus = {dw[127:0], dw[255:128]};
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        `CHK(wait_rq, 1'b1)
        avs(1'b0, 2'h0, 32'h0);
        `CHK(rv, 32'h4)
        // Plain, masked, auto-masked writes back to back
        u_ctrl.wcol(3'h3, 4'h0, 1'b0, 0, dm);
        @(posedge clk);
        u_ctrl.wcol(3'h2, 4'h0, 1'b1, 8'hA5, dm);
        @(posedge clk);
        `CHK({od.valid, ev.valid, od.data}, {2'b10, dm})
        `CHK(od.byte_en, 32'hFFFFFFFF)
        u_ctrl.wcol(3'h0, 4'h0, 1'b1, -1, dm);
        @(posedge clk);
        `CHK({od.valid, ev.valid, ev.byte_en}, {2'b01, 32'h1})
        u_ctrl.idle;
        @(posedge clk);
        `CHK(ev.byte_en, 32'hFFFFFFFF)
        for (int w = 0; w < 5; w++)
        begin
            pins = 1 << w;
            lm = pins - 1;
            avs(1'b1, 2'h0, 32'(w));
            u_ctrl.wcol(3'(w), 4'hB, 1'b0, 0, dw);
            u_ctrl.rcol(3'(w), 4'hB);
            @(posedge clk);
            u_ctrl.idle;
            @(posedge clk);
            cw = w[0] ? od : ev;
            rb = w[0] ? obus : ebus;
            for (int j = 0; j < 16; j++)
            begin
                sel = (j & ~lm) == (11 & ~lm);
                `CHK(cw.byte_en[2*j+:2], sel ? 2'h3 : 2'h0)
                if (sel)
                    `CHK(cw.data[j*16+:16], dw[(j & lm)*16+:16])
                `CHK(rpin[j*16+:16], j < pins ? rb[((11 & ~lm) | j)*16+:16] : 16'h0)
            end
            `CHK({rvld, ren}, {1'b1, 16'((1 << pins) - 1)})
        end
        // Undefined width code drops both directions
        avs(1'b1, 2'h0, 32'h5);
        u_ctrl.wcol(3'h1, 4'h0, 1'b0, 0, dw);
        u_ctrl.rcol(3'h1, 4'h0);
        @(posedge clk);
        u_ctrl.idle;
        @(posedge clk);
        `CHK({od.valid, ev.valid, rvld}, 3'b000)
        // Counters: 8 accepted writes, 2 masked, 5 reads; refused width flagged
        avs(1'b0, 2'h2, 32'h0);
        `CHK(rv, 32'h00020008)
        @(posedge clk);
        avs(1'b0, 2'h3, 32'h0);
        `CHK(rv, 32'h00000005)
        @(posedge clk);
        avs(1'b0, 2'h1, 32'h0);
        `CHK(rv, 32'h00000008)
        stop_test;
    end
endmodule : dwmb_top_bench
